// >>> core/twh_defs.vh
// Purpose: constants of the two-wire host command path
// Assumes: 32-bit APB data, byte addresses
// Notes:   definitions only
`ifndef TWH_DEFS_VH
`define TWH_DEFS_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define TWH_CTRL_OFS   8'h00
`define TWH_TIME_OFS   8'h08
`define TWH_ACT_OFS    8'h0C
`define TWH_QUE_OFS    8'h10
`define TWH_RXH_OFS    8'h14
`define TWH_TXH_OFS    8'h18
`define TWH_STAT_OFS   8'h1C
`define TWH_SCLR_OFS   8'h2C
// ------------------------------------------------------------
// Command word fields
// ------------------------------------------------------------
`define TWH_C_ACKL     25
`define TWH_C_PEC      24
`define TWH_C_CNT_HI   23
`define TWH_C_CNT_LO   16
`define TWH_C_VALID    15
`define TWH_C_STOP     14
`define TWH_C_START    13
`define TWH_C_REPS     12
`define TWH_C_WIDE     11
`define TWH_C_ADR_HI   10
`define TWH_C_ADR_LO   1
`define TWH_C_READ     0
// ------------------------------------------------------------
// Status, clear, control and time fields
// ------------------------------------------------------------
`define TWH_S_RXA      0
`define TWH_S_TXR      1
`define TWH_S_COMMAND_SLOT_FREE     2
`define TWH_S_CCOMP    3
`define TWH_S_IDLE     4
`define TWH_S_BUS_TIMEOUT_FLAG     12
`define TWH_S_PACKET_CHECK_MISMATCH   13
`define TWH_S_STOPACC  14
`define TWH_S_ENB      16
`define TWH_STAT_RST   32'h0000_0002
`define TWH_K_EN       0
`define TWH_K_DIS      1
`define TWH_K_SMEN     4
`define TWH_K_SMDIS    5
`define TWH_K_STOP     8
`define TWH_T_LIM_HI   7
`define TWH_T_LIM_LO   0
`define TWH_T_EXP_HI   31
`define TWH_T_EXP_LO   28
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TWH_CLK_HZ     250000000
`define TWH_BUS_HZ     100000
`define TWH_QTR_CYC    (`TWH_CLK_HZ / (4 * `TWH_BUS_HZ))
`endif

// >>> core/twh_host.v
// Purpose: two-wire host command path with APB registers
// Assumes: open-drain pins resolved outside; scl/sda async
// Notes:   one quarter-bit tick drives the START, bit and STOP waveforms
//
// The APB slave port is this design's own decision.
`include "twh_defs.vh"
module twh_host #(
   parameter QTR_CYC = `TWH_QTR_CYC
) (
   input  wire        core_clk,  // 250 MHz clock
   input  wire        nrst,      // async reset, low
   input  wire        psel,      // APB select
   input  wire        penable,   // APB enable
   input  wire        pwrite,    // APB direction
   input  wire [7:0]  paddr,     // APB byte address
   input  wire [31:0] pwdata,    // APB write data
   output reg  [31:0] prdata,    // APB read data
   output reg         pready,    // APB ready
   output reg         pslverr,   // APB error
   input  wire        scl_in,    // clock pin level
   output reg         scl_out,   // clock pin drive value
   output reg         scl_oe,    // clock pin pull low
   input  wire        sda_in,    // data pin level
   output reg         sda_out,   // data pin drive value
   output reg         sda_oe     // data pin pull low
);
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_START = 3'd1;
   localparam [2:0] S_TXB   = 3'd2;
   localparam [2:0] S_RXB   = 3'd3;
   localparam [2:0] S_NEXT  = 3'd4;
   localparam [2:0] S_DATA  = 3'd5;
   localparam [2:0] S_STOP  = 3'd6;
   localparam [2:0] S_DONE  = 3'd7;
   localparam [31:0] QTOP_W = QTR_CYC - 1;
   localparam [9:0] QTOP    = QTOP_W[9:0];

   reg  [31:0] act_reg;
   reg  [31:0] act_next;
   reg  [31:0] que_reg;
   reg  [31:0] que_next;
   reg  [31:0] time_reg;
   reg         en_reg;
   reg         smb_reg;
   reg         ccomp_reg;
   reg         bus_timeout_flag_reg;
   reg         packet_check_mismatch_reg;
   reg         stopacc_reg;
   reg  [2:0]  st_reg;
   reg  [1:0]  q_reg;
   reg  [9:0]  qcnt_reg;
   reg  [3:0]  bit_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  crc_reg;
   reg  [7:0]  rem_reg;
   reg  [1:0]  step_reg;
   reg         addr_ph_reg;
   reg         nack_reg;
   reg         abort_reg;
   reg         held_reg;
   reg         stop_req_reg;
   reg  [7:0]  rx_reg;
   reg         rx_av_reg;
   reg  [7:0]  tx_reg;
   reg         tx_full_reg;
   reg         ev_ccomp;
   reg         ev_bus_timeout_flag;
   reg         ev_pec;
   reg         ev_stop;
   reg         kill_que;
   reg  [16:0] pre_reg;
   reg  [7:0]  str_reg;
   reg  [2:0]  scl_sy;
   reg  [2:0]  sda_sy;
   reg         scl_f;
   reg         sda_f;
   reg  [31:0] rd_mux;
   reg         rd_err;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire acc    = psel & penable & pready;
   wire wr     = acc & pwrite;
   wire wr_ctl = wr & (paddr == `TWH_CTRL_OFS);
   wire wr_tim = wr & (paddr == `TWH_TIME_OFS);
   wire wr_act = wr & (paddr == `TWH_ACT_OFS);
   wire wr_que = wr & (paddr == `TWH_QUE_OFS);
   wire wr_tx  = wr & (paddr == `TWH_TXH_OFS);
   wire wr_clr = wr & (paddr == `TWH_SCLR_OFS);
   wire rd_rx  = acc & ~pwrite & (paddr == `TWH_RXH_OFS);

   wire       rd_dir  = act_reg[`TWH_C_READ];
   wire [9:0] tadr    = act_reg[`TWH_C_ADR_HI:`TWH_C_ADR_LO];
   wire       wide    = act_reg[`TWH_C_WIDE] & ~smb_reg;
   wire       pec_use = act_reg[`TWH_C_PEC] & smb_reg;
   wire       ack_drv = (rem_reg != 8'h01) | act_reg[`TWH_C_ACKL];
   wire       last_rx = (rem_reg == 8'h01);
   wire [7:0] addr_b  = (step_reg == 2'd1) ? tadr[7:0] :
                        (~wide) ? {tadr[6:0], rd_dir} :
                        {5'b11110, tadr[9:8], (step_reg == 2'd2)};
   wire       bit_in  = (st_reg == S_RXB) ? sda_f : shift_reg[7];
   wire [7:0] crc_nx  = {crc_reg[6:0], 1'b0} ^
                        ((crc_reg[7] ^ sda_f) ? 8'h07 : 8'h00);
   wire       qtick   = (qcnt_reg == QTOP);
   wire       waiting = (q_reg == 2'd2) & ~scl_f;
   wire       rx_stl  = (st_reg == S_RXB) & (bit_reg == 4'd8) &
                        (q_reg == 2'd0) & rx_av_reg;
   wire       adv     = qtick & ~waiting & ~rx_stl;
   wire       on_bus  = (st_reg == S_START) | (st_reg == S_TXB) |
                        (st_reg == S_RXB) | (st_reg == S_STOP);
   wire [3:0] pexp    = time_reg[`TWH_T_EXP_HI:`TWH_T_EXP_LO];
   wire [16:0] pre_top = (17'h0_0001 << ({1'b0, pexp} + 5'd1)) - 17'h0_0001;
   wire       pre_tk  = (pre_reg == pre_top);
   wire [7:0] lim     = time_reg[`TWH_T_LIM_HI:`TWH_T_LIM_LO];
   wire       tmo     = on_bus & waiting & pre_tk & (lim != 8'h00) &
                        (str_reg >= lim);
   wire       done    = (st_reg == S_DONE);
   wire       command_slot_free    = en_reg & (~act_reg[`TWH_C_VALID] |
                        ~que_reg[`TWH_C_VALID]);
   wire       idle    = en_reg & (st_reg == S_IDLE) &
                        ~act_reg[`TWH_C_VALID] & ~que_reg[`TWH_C_VALID];
   wire [31:0] stat   = {15'h0000, en_reg, 1'b0, stopacc_reg, packet_check_mismatch_reg,
                         bus_timeout_flag_reg, 4'h0, 3'h0, idle, ccomp_reg, command_slot_free,
                         ~tx_full_reg, rx_av_reg};

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // A level counts only once the two later stages agree
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_sy <= 3'b111;
         sda_sy <= 3'b111;
         scl_f  <= 1'b1;
         sda_f  <= 1'b1;
      end
      else
      begin
         scl_sy <= {scl_sy[1:0], scl_in};
         sda_sy <= {sda_sy[1:0], sda_in};
         if (scl_sy[2] == scl_sy[1])
            scl_f <= scl_sy[2];
         if (sda_sy[2] == sda_sy[1])
            sda_f <= sda_sy[2];
      end
   end

   // ------------------------------------------------------------
   // Command registers
   // ------------------------------------------------------------
   always @*
   begin
      act_next = act_reg;
      que_next = que_reg;
      if (wr_act)
         act_next = pwdata;
      if (wr_que)
         que_next = pwdata;
      if (done)
         act_next[`TWH_C_VALID] = 1'b0;
      if (kill_que)
         que_next[`TWH_C_VALID] = 1'b0;
      if (~act_next[`TWH_C_VALID] & que_next[`TWH_C_VALID])
      begin
         act_next = que_next;
         que_next[`TWH_C_VALID] = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // APB slave and flags
   // ------------------------------------------------------------
   always @*
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         `TWH_CTRL_OFS : rd_mux = 32'h0000_0000;
         `TWH_TIME_OFS : rd_mux = time_reg;
         `TWH_ACT_OFS  : rd_mux = act_reg;
         `TWH_QUE_OFS  : rd_mux = que_reg;
         `TWH_RXH_OFS  : rd_mux = {24'h00_0000, rx_reg};
         `TWH_TXH_OFS  : rd_mux = 32'h0000_0000;
         `TWH_STAT_OFS : rd_mux = stat;
         `TWH_SCLR_OFS : rd_mux = 32'h0000_0000;
         default       : rd_err = 1'b1;
      endcase
   end

   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready      <= 1'b0;
         prdata      <= 32'h0000_0000;
         pslverr     <= 1'b0;
         act_reg     <= 32'h0000_0000;
         que_reg     <= 32'h0000_0000;
         time_reg    <= 32'h0000_0000;
         en_reg      <= 1'b0;
         smb_reg     <= 1'b0;
         ccomp_reg   <= 1'b0;
         bus_timeout_flag_reg    <= 1'b0;
         packet_check_mismatch_reg  <= 1'b0;
         stopacc_reg <= 1'b0;
      end
      else
      begin
         // One wait state: data and error register in the same cycle as ready
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & rd_err;
         act_reg <= act_next;
         que_reg <= que_next;
         if (wr_tim)
            time_reg <= pwdata;
         if (wr_ctl & pwdata[`TWH_K_EN])
            en_reg <= 1'b1;
         if (wr_ctl & pwdata[`TWH_K_DIS])
            en_reg <= 1'b0;
         if (wr_ctl & pwdata[`TWH_K_SMEN])
            smb_reg <= 1'b1;
         if (wr_ctl & pwdata[`TWH_K_SMDIS])
            smb_reg <= 1'b0;
         // Set wins over a clear in the same cycle
         ccomp_reg   <= (ccomp_reg & ~(wr_clr & pwdata[`TWH_S_CCOMP])) |
                        ev_ccomp;
         bus_timeout_flag_reg    <= (bus_timeout_flag_reg & ~(wr_clr & pwdata[`TWH_S_BUS_TIMEOUT_FLAG])) |
                        ev_bus_timeout_flag;
         packet_check_mismatch_reg  <= (packet_check_mismatch_reg & ~(wr_clr & pwdata[`TWH_S_PACKET_CHECK_MISMATCH])) |
                        ev_pec;
         stopacc_reg <= (stopacc_reg & ~(wr_clr & pwdata[`TWH_S_STOPACC])) |
                        ev_stop;
      end
   end

   // ------------------------------------------------------------
   // Bus engine
   // ------------------------------------------------------------
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg       <= S_IDLE;
         q_reg        <= 2'd0;
         qcnt_reg     <= 10'h000;
         bit_reg      <= 4'h0;
         shift_reg    <= 8'h00;
         crc_reg      <= 8'h00;
         rem_reg      <= 8'h00;
         step_reg     <= 2'd0;
         addr_ph_reg  <= 1'b0;
         nack_reg     <= 1'b0;
         abort_reg    <= 1'b0;
         held_reg     <= 1'b0;
         stop_req_reg <= 1'b0;
         rx_reg       <= 8'h00;
         rx_av_reg    <= 1'b0;
         tx_reg       <= 8'h00;
         tx_full_reg  <= 1'b0;
         ev_ccomp     <= 1'b0;
         ev_bus_timeout_flag      <= 1'b0;
         ev_pec       <= 1'b0;
         ev_stop      <= 1'b0;
         kill_que     <= 1'b0;
         pre_reg      <= 17'h0_0000;
         str_reg      <= 8'h00;
         scl_out      <= 1'b0;
         scl_oe       <= 1'b0;
         sda_out      <= 1'b0;
         sda_oe       <= 1'b0;
      end
      else
      begin
         ev_ccomp <= 1'b0;
         ev_bus_timeout_flag  <= 1'b0;
         ev_pec   <= 1'b0;
         ev_stop  <= 1'b0;
         kill_que <= 1'b0;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         qcnt_reg <= (qtick | ~on_bus) ? 10'h000 : qcnt_reg + 10'h001;
         if (rd_rx)
            rx_av_reg <= 1'b0;
         if (wr_tx)
         begin
            tx_reg      <= pwdata[7:0];
            tx_full_reg <= 1'b1;
         end
         // Cumulative stretch time of the whole command
         if (on_bus & waiting)
         begin
            pre_reg <= pre_tk ? 17'h0_0000 : pre_reg + 17'h0_0001;
            if (pre_tk & (str_reg != 8'hFF))
               str_reg <= str_reg + 8'h01;
         end
         case (st_reg)
            S_IDLE:
            begin
               q_reg <= 2'd0;
               if (stop_req_reg)
               begin
                  if (held_reg)
                  begin
                     abort_reg <= 1'b1;
                     st_reg    <= S_STOP;
                  end
                  else
                  begin
                     stop_req_reg <= 1'b0;
                     ev_stop      <= 1'b1;
                  end
               end
               else if (en_reg & act_reg[`TWH_C_VALID])
               begin
                  rem_reg   <= act_reg[`TWH_C_CNT_HI:`TWH_C_CNT_LO];
                  abort_reg <= 1'b0;
                  str_reg   <= 8'h00;
                  pre_reg   <= 17'h0_0000;
                  if (act_reg[`TWH_C_START])
                  begin
                     // Same waveform serves START and repeated START
                     st_reg   <= S_START;
                     step_reg <= (wide & rd_dir & act_reg[`TWH_C_REPS]) ?
                                 2'd2 : 2'd0;
                  end
                  else
                     st_reg <= S_DATA;
               end
            end
            S_START:
               if (adv)
               begin
                  q_reg <= q_reg + 2'd1;
                  case (q_reg)
                     2'd0: sda_oe <= 1'b0;
                     2'd1: scl_oe <= 1'b0;
                     2'd2: sda_oe <= 1'b1;
                     default:
                     begin
                        scl_oe      <= 1'b1;
                        held_reg    <= 1'b1;
                        crc_reg     <= 8'h00;
                        shift_reg   <= addr_b;
                        bit_reg     <= 4'h0;
                        addr_ph_reg <= 1'b1;
                        st_reg      <= S_TXB;
                     end
                  endcase
               end
            S_TXB, S_RXB:
               if (adv)
               begin
                  q_reg <= q_reg + 2'd1;
                  case (q_reg)
                     2'd0:
                        if (bit_reg != 4'd8)
                           sda_oe <= (st_reg == S_TXB) & ~bit_in;
                        else if (st_reg == S_TXB)
                           sda_oe <= 1'b0;
                        else
                        begin
                           sda_oe    <= ack_drv;
                           rx_reg    <= shift_reg;
                           rx_av_reg <= 1'b1;
                           if (pec_use & last_rx & (crc_reg != 8'h00))
                              ev_pec <= 1'b1;
                        end
                     2'd1: scl_oe <= 1'b0;
                     2'd2:
                        if (bit_reg != 4'd8)
                        begin
                           crc_reg   <= crc_nx;
                           shift_reg <= {shift_reg[6:0], sda_f};
                        end
                        else if (st_reg == S_TXB)
                           nack_reg <= sda_f;
                     default:
                     begin
                        scl_oe <= 1'b1;
                        if (bit_reg == 4'd8)
                        begin
                           bit_reg <= 4'h0;
                           st_reg  <= S_NEXT;
                        end
                        else
                           bit_reg <= bit_reg + 4'h1;
                     end
                  endcase
               end
            S_NEXT:
            begin
               q_reg <= 2'd0;
               if (~addr_ph_reg)
                  rem_reg <= rem_reg - 8'h01;
               if ((nack_reg & (~addr_ph_reg ? ~rd_dir : 1'b1)) | stop_req_reg)
               begin
                  nack_reg  <= 1'b0;
                  abort_reg <= 1'b1;
                  st_reg    <= S_STOP;
               end
               else if (addr_ph_reg & wide & (step_reg == 2'd0))
               begin
                  step_reg  <= 2'd1;
                  shift_reg <= tadr[7:0];
                  st_reg    <= S_TXB;
               end
               else if (addr_ph_reg & wide & (step_reg == 2'd1) & rd_dir)
               begin
                  step_reg <= 2'd2;
                  st_reg   <= S_START;
               end
               else
               begin
                  addr_ph_reg <= 1'b0;
                  st_reg      <= S_DATA;
               end
            end
            S_DATA:
            begin
               q_reg <= 2'd0;
               if (stop_req_reg)
               begin
                  abort_reg <= 1'b1;
                  st_reg    <= S_STOP;
               end
               else if (rem_reg == 8'h00)
                  st_reg <= act_reg[`TWH_C_STOP] ? S_STOP : S_DONE;
               else if (rd_dir)
                  st_reg <= S_RXB;
               else if (pec_use & (rem_reg == 8'h01))
               begin
                  shift_reg <= crc_reg;
                  st_reg    <= S_TXB;
               end
               else if (tx_full_reg)
               begin
                  shift_reg   <= tx_reg;
                  tx_full_reg <= wr_tx;
                  st_reg      <= S_TXB;
               end
            end
            S_STOP:
               if (adv)
               begin
                  q_reg <= q_reg + 2'd1;
                  case (q_reg)
                     2'd0: sda_oe <= 1'b1;
                     2'd1: scl_oe <= 1'b0;
                     2'd2: sda_oe <= 1'b0;
                     default:
                     begin
                        held_reg <= 1'b0;
                        st_reg   <= S_DONE;
                     end
                  endcase
               end
            S_DONE:
            begin
               st_reg <= S_IDLE;
               if (stop_req_reg)
               begin
                  // The queued command has already moved up and still runs; kill_que lands one cycle later
                  stop_req_reg <= 1'b0;
                  ev_stop      <= 1'b1;
                  kill_que     <= 1'b1;
               end
               else if (~abort_reg & act_reg[`TWH_C_STOP])
                  ev_ccomp <= 1'b1;
            end
            default: st_reg <= S_IDLE;
         endcase
         // Timeout releases the bus at once, possibly mid-byte
         if (tmo)
         begin
            ev_bus_timeout_flag   <= 1'b1;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
            held_reg  <= 1'b0;
            abort_reg <= 1'b1;
            st_reg    <= S_DONE;
         end
         if (wr_ctl & pwdata[`TWH_K_STOP])
            stop_req_reg <= 1'b1;
      end
   end
endmodule // twh_host

// >>> tb/twh_host_asserts.sv
// Purpose: port checks of the two-wire host
// Assumes: one clock domain, nrst async low
// Notes:   APB answers after one wait state
module twh_host_asserts (
   input wire logic        core_clk, // clock
   input wire logic        nrst,     // reset, low
   input wire logic        psel,     // select
   input wire logic        penable,  // enable
   input wire logic        pwrite,   // direction
   input wire logic [7:0]  paddr,    // address
   input wire logic [31:0] prdata,   // read data
   input wire logic        pready,   // ready
   input wire logic        pslverr,  // error
   input wire logic        scl_out,  // clock value
   input wire logic        sda_out   // data value
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------
   // Access steps
   // ----------------------------------------
   sequence s_first_acc;
      psel && penable && !$past(penable);
   endsequence
   sequence s_rd(a);
      pready && psel && !pwrite && paddr == a;
   endsequence
   chk_one_wait: assert property (s_first_acc |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_unmapped_err: assert property (pready |-> pslverr == !(paddr inside
      {8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h2c}))
      else $error("error flag wrong for address");
   chk_idle_rdata: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside answer");
   chk_tx_wonly: assert property (s_rd(8'h18) |-> prdata == 32'h0000_0000)
      else $error("transmit holding readable");
   chk_rx_byte: assert property (s_rd(8'h14) |-> prdata[31:8] == 24'h00_0000)
      else $error("receive holding above low byte");
   chk_stat_rsvd: assert property (s_rd(8'h1c) |-> prdata[31:17] == 0 && prdata[11:5] == 0)
      else $error("status reserved bits set");
   chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("pin drive value not low");
endmodule // twh_host_asserts

// >>> tb/twh_target.sv
// Purpose: behavioural target on the two-wire bus
// Assumes: 7-bit address, no clock stretch
// Notes:   read bytes count up from the first value
module twh_target #(
   parameter logic [6:0] ADDR  = 7'h2a, // own address
   parameter logic [7:0] RDATA = 8'h5c  // first read byte
) (
   input  wire logic scl,    // bus clock level
   input  wire logic sda,    // bus data level
   output logic      sda_low // pulls data low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh, txb, got[$];
   int         bc;
   logic       act, first, rd, mine, last_ack;
   initial
   begin
      sda_low = 0;
      act = 0;
      txb = RDATA;
   end
   always @(negedge sda)
      if (scl)
      begin
         act = 1;
         first = 1;
         bc = 0;
         last_ack = 0;
      end
   always @(posedge sda)
      if (scl)
         act = 0;
   always @(posedge scl)
      if (act)
      begin
         bc = bc + 1;
         if (bc < 9)
            sh = {sh[6:0], sda};
         else if (rd && !first)
            last_ack = sda;
      end
   always @(negedge scl)
      if (act)
      begin
         if (bc == 8)
         begin
            if (first)
            begin
               mine = sh[7:1] == ADDR;
               rd = sh[0];
            end
            else if (!rd)
               got.push_back(sh);
            sda_low = mine && (first || !rd);
         end
         else if (bc == 9)
         begin
            bc = 0;
            first = 0;
            sda_low = 0;
         end
         // Stop driving after a refusal so the STOP can pass
         if (mine && rd && !first && !last_ack && bc < 8)
         begin
            sda_low = !txb[7 - bc];
            if (bc == 7)
               txb = txb + 1;
         end
      end
endmodule // twh_target

// >>> tb/twh_host_tb.sv
// Purpose: self-checking bench of the two-wire host
// Assumes: quarter tick shortened to 4 cycles
// Notes:   target model on the far side
module twh_host_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] CW = 32'h0001_e554;
   localparam logic [31:0] CR = 32'h0002_e555;
   logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        scl_out, scl_oe, sda_out, sda_oe, tgt_low;
   wire         scl = !scl_oe;
   wire         sda = !(sda_oe || tgt_low);
   int          errors, cmp_count;
   twh_host #(.QTR_CYC(4)) i_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   twh_target i_tgt (.scl(scl), .sda(sda), .sda_low(tgt_low));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_stat(input int b);
      repeat (500)
      begin
         bus(0, 8'h1c, 0);
         if (rd[b] === 1'b1)
            break;
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      bus(0, 8'h1c, 0);
      chk(rd, 32'h0000_0002);
      bus(0, 8'h0c, 0);
      chk(rd, 0);
      bus(0, 8'h04, 0);
      chk({31'h0, err}, 1);
   endtask
   task automatic t_queue;
      bus(1, 8'h10, 32'h0001_8054);
      bus(0, 8'h0c, 0);
      chk(rd, 32'h0001_8054);
      bus(1, 8'h10, 32'h0003_8056);
      bus(0, 8'h10, 0);
      chk(rd, 32'h0003_8056);
      bus(1, 8'h0c, 0);
      bus(0, 8'h0c, 0);
      chk(rd, 32'h0003_8056);
      bus(0, 8'h10, 0);
      chk(rd[15], 0);
      bus(1, 8'h0c, 0);
   endtask
   task automatic t_write;
      bus(1, 8'h00, 1);
      bus(0, 8'h1c, 0);
      chk(rd & 32'h0001_0004, 32'h0001_0004);
      bus(1, 8'h18, 8'ha5);
      bus(1, 8'h0c, CW);
      wait_stat(3);
      chk({24'h0, i_tgt.got[0]}, 8'ha5);
      chk({30'h0, scl, sda}, 3);
      bus(0, 8'h0c, 0);
      chk(rd[15], 0);
      bus(1, 8'h2c, 0);
      bus(0, 8'h1c, 0);
      chk(rd[3], 1);
      bus(1, 8'h2c, 8);
      bus(0, 8'h1c, 0);
      chk(rd[3], 0);
   endtask
   task automatic t_flags;
      bus(1, 8'h08, 32'h0000_0001);
      bus(1, 8'h0c, CW);
      wait_stat(12);
      chk(rd[12], 1);
      bus(0, 8'h0c, 0);
      chk(rd[15], 0);
      bus(1, 8'h08, 0);
      bus(1, 8'h2c, 32'h0000_1000);
      bus(1, 8'h00, 32'h0000_0100);
      bus(0, 8'h1c, 0);
      chk(rd & 32'h0000_7008, 32'h0000_4000);
      bus(1, 8'h2c, 32'h0000_4000);
      bus(0, 8'h1c, 0);
      chk(rd[14], 0);
   endtask
   task automatic t_read;
      bus(1, 8'h0c, CR);
      for (int i = 0; i < 2; i++)
      begin
         wait_stat(0);
         bus(0, 8'h14, 0);
         chk(rd, 8'h5c + i);
      end
      wait_stat(3);
      chk({31'h0, i_tgt.last_ack}, 1);
      bus(1, 8'h00, 2);
      bus(0, 8'h1c, 0);
      chk(rd[16], 0);
   endtask
   initial
   begin
      core_clk = 0;
      forever #2 core_clk = !core_clk;
   end
   initial
   begin
      #300000;
      errors++;
      print_verdict;
   end
   initial
   begin
      nrst = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      repeat (20) @(posedge core_clk);
      nrst <= 1;
      t_reset;
      t_queue;
      t_write;
      t_flags;
      t_read;
      print_verdict;
   end
endmodule // twh_host_tb
bind twh_host twh_host_asserts i_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .scl_out(scl_out), .sda_out(sda_out));
